// ---- shared/i2res_pkg.sv ----
// Constants, offsets and carrier types of the raw event status block.
// Assumes one 20 MHz system clock and a controller core on that clock.
// Functional notes
// - Raw status shows flags without any masking
// - Bit 13 master holds bus, both configs on
// - Bit 12 repeated start while slave addressed
// - No repeated-start flag in high-speed or start-byte
// - Bit 11 set on acknowledged broadcast call
// - Broadcast flag clears by disable or clear read
// - Broadcast call data go to receive buffer
// - Bit 10 set on any start or repeat
// - Bit 9 set on stop, per qualifying options
// - Control bit 7 limits slave stop to addressed
// - Broadcast call never qualifies addressed stop
// - Control bit 10 limits master stop to active
// - Bit 8 latches activity until cleared
// - Bit 7 set on slave-transmit missing acknowledge
// - Flags one when active, reset zero, 31:14 reserved
// - Masked status is raw and active-low mask
package i2res_pkg;

  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam int unsigned FW = 14;

  // Register offsets
  localparam logic [AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [AW-1:0] OFF_MSTAT = 8'h2c;
  localparam logic [AW-1:0] OFF_MASK = 8'h30;
  localparam logic [AW-1:0] OFF_RAW = 8'h34;
  localparam logic [AW-1:0] OFF_CLR_ALL = 8'h40;
  localparam logic [AW-1:0] OFF_CLR_ACT = 8'h5c;
  localparam logic [AW-1:0] OFF_CLR_GC = 8'h68;
  localparam logic [AW-1:0] OFF_ENABLE = 8'h6c;
  localparam logic [AW-1:0] OFF_CFG = 8'h80;

  // Status bit positions
  localparam int unsigned B_HOLD = 13;
  localparam int unsigned B_RSTRT = 12;
  localparam int unsigned B_GC = 11;
  localparam int unsigned B_START = 10;
  localparam int unsigned B_STOP = 9;
  localparam int unsigned B_ACT = 8;
  localparam int unsigned B_TXDONE = 7;
  localparam int unsigned B_LOW_TOP = 6;

  // Control and configuration field positions
  localparam int unsigned C_STOP_ADDR = 7;
  localparam int unsigned C_STOP_MACT = 10;
  localparam int unsigned G_DYN_TAR = 0;
  localparam int unsigned G_HOLD_EN = 1;
  localparam int unsigned G_RS_DET = 2;
  localparam int unsigned E_EN = 0;
  localparam int unsigned GC_CLR_BIT = 0;

  // Reset values
  localparam logic [FW-1:0] MASK_RST = 14'h08ff;
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam logic [FW-1:0] FLAG_RST = 14'h0000;
  localparam logic [DW-1:0] RD_ZERO = 32'h0000_0000;

  // Events and levels from the controller core
  typedef struct packed {
    logic slave_mode;
    logic master_active;
    logic addr_match;
    logic gc_ack;
    logic slv_tx_nack;
    logic master_hold;
    logic hs_or_sbyte;
    logic core_busy;
  } i2res_core_s;

  // Register port request
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } i2res_req_s;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_BUSY = 1'b1
  } i2res_bus_e;

endpackage

// ---- rtl/i2res_status.sv ----
// Raw event status, mask, masked status and interrupt of a two-wire
// bus controller. Assumes the core reports its events on i_clk and
// that the bus lines arrive unsynchronised from the pads.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module i2res_status
  import i2res_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register port
  input wire i2res_req_s i_req,
  output logic [DW-1:0] o_rdata,
  // Bus lines from the pads
  input wire logic i_scl,
  input wire logic i_sda,
  // Controller core
  input wire i2res_core_s i_core,
  input wire logic [B_LOW_TOP:0] i_low_raw,
  // To the rest of the controller
  output logic o_enabled,
  output logic o_rx_store_en,
  output logic [FW-1:0] o_masked,
  output logic o_irq
);

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic start_ev;
  logic stop_ev;
  i2res_bus_e bus_q;
  i2res_bus_e bus_d;
  logic restart_ev;

  logic [10:0] ctrl_q;
  logic [2:0] cfg_q;
  logic en_q;
  logic [FW-1:0] mask_q;
  logic [DW-1:0] rdata_q;

  logic addr_own_q;
  logic addr_gc_q;
  logic stop_ok;
  logic stop_slave_ok;
  logic stop_master_ok;
  logic rs_ok;
  logic hold_lvl;

  logic [B_RSTRT:B_TXDONE] flag_q;
  logic [B_RSTRT:B_TXDONE] set_vec;
  logic [B_RSTRT:B_TXDONE] clr_vec;
  logic [FW-1:0] raw;
  logic [FW-1:0] masked;
  logic [FW-1:0] masked_q;
  logic irq_q;

  logic set_rstrt;
  logic set_gc;
  logic set_start;
  logic set_stop;
  logic set_act;
  logic set_txdone;

  logic wr_hit_ctrl;
  logic wr_hit_cfg;
  logic wr_hit_en;
  logic wr_hit_mask;
  logic wr_hit_clr_all;
  logic rd_clr_all;
  logic rd_clr_act;
  logic rd_clr_gc;

  // Two flops on each pad line; only the second stage is read
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
    end else begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // Data edge while the clock line stays high marks start or stop
  assign start_ev = scl_prev_q & scl_sync_q[1] & sda_prev_q & ~sda_sync_q[1];
  assign stop_ev = scl_prev_q & scl_sync_q[1] & ~sda_prev_q & sda_sync_q[1];

  // A start seen while the bus is already busy is a repeated start
  assign restart_ev = start_ev & (bus_q == BUS_BUSY);

  always_comb begin
    bus_d = bus_q;
    case (bus_q)
      BUS_IDLE: begin
        if (start_ev) begin
          bus_d = BUS_BUSY;
        end
      end
      BUS_BUSY: begin
        if (stop_ev) begin
          bus_d = BUS_IDLE;
        end
      end
      default: begin
        bus_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      bus_q <= BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  // Register decode
  assign wr_hit_ctrl = i_req.wr & (i_req.addr == OFF_CTRL);
  assign wr_hit_cfg = i_req.wr & (i_req.addr == OFF_CFG);
  assign wr_hit_en = i_req.wr & (i_req.addr == OFF_ENABLE);
  assign wr_hit_mask = i_req.wr & (i_req.addr == OFF_MASK);
  assign wr_hit_clr_all = i_req.wr & (i_req.addr == OFF_CLR_ALL);
  assign rd_clr_all = i_req.rd & (i_req.addr == OFF_CLR_ALL);
  assign rd_clr_act = i_req.rd & (i_req.addr == OFF_CLR_ACT);
  assign rd_clr_gc = i_req.rd & (i_req.addr == OFF_CLR_GC);

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_hit_ctrl) begin
      ctrl_q <= i_req.wdata[10:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cfg_q <= CFG_RST;
    end else if (wr_hit_cfg) begin
      cfg_q <= i_req.wdata[2:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      en_q <= 1'b0;
    end else if (wr_hit_en) begin
      en_q <= i_req.wdata[E_EN];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      mask_q <= MASK_RST;
    end else if (wr_hit_mask) begin
      mask_q <= i_req.wdata[FW-1:0];
    end
  end

  // Which address qualified this transfer; a repeated start keeps the own-address match but clears the broadcast one
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      addr_own_q <= 1'b0;
    end else if (i_core.addr_match) begin
      addr_own_q <= 1'b1;
    end else if (!en_q || stop_ev || (start_ev && !restart_ev)) begin
      addr_own_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      addr_gc_q <= 1'b0;
    end else if (i_core.gc_ack) begin
      addr_gc_q <= 1'b1;
    end else if (!en_q || stop_ev || start_ev) begin
      addr_gc_q <= 1'b0;
    end
  end

  // Broadcast data land in the receive buffer like addressed data
  assign o_rx_store_en = en_q & (addr_own_q | addr_gc_q | i_core.gc_ack);

  // Slave stop: optionally only the own address qualifies, never broadcast
  assign stop_slave_ok = ~ctrl_q[C_STOP_ADDR] | addr_own_q;
  // Master stop: optionally only while the master is active
  assign stop_master_ok = ~ctrl_q[C_STOP_MACT] | i_core.master_active;
  assign stop_ok = i_core.slave_mode ? stop_slave_ok : stop_master_ok;

  // Before the address in high-speed or start-byte we are not addressed
  assign rs_ok = cfg_q[G_RS_DET] & i_core.slave_mode & addr_own_q
               & ~i_core.hs_or_sbyte;

  // Hold is a live level, not a latched event
  assign hold_lvl = en_q & cfg_q[G_DYN_TAR] & cfg_q[G_HOLD_EN] & i_core.master_hold;

  // Per-flag set terms
  assign set_rstrt = restart_ev & rs_ok;
  assign set_gc = i_core.gc_ack;
  assign set_start = start_ev;
  assign set_stop = stop_ev & stop_ok;
  // Busy keeps re-arming activity, so a clear only sticks once idle
  assign set_act = i_core.core_busy | (bus_q == BUS_BUSY) | start_ev;
  assign set_txdone = i_core.slv_tx_nack & i_core.slave_mode;

  always_comb begin
    set_vec = '0;
    set_vec[B_RSTRT] = set_rstrt;
    set_vec[B_GC] = set_gc;
    set_vec[B_START] = set_start;
    set_vec[B_STOP] = set_stop;
    set_vec[B_ACT] = set_act;
    set_vec[B_TXDONE] = set_txdone;
  end

  // Clear sources per flag; raw status reads are not among them
  always_comb begin
    clr_vec = '0;
    if (wr_hit_clr_all) begin
      clr_vec = i_req.wdata[B_RSTRT:B_TXDONE];
    end
    if (rd_clr_all) begin
      clr_vec = '1;
    end
    clr_vec[B_GC] = rd_clr_gc;
    clr_vec[B_ACT] = rd_clr_act | rd_clr_all;
  end

  // A set in the same cycle as a clear wins so no event is lost
  genvar gi;
  generate
    for (gi = B_TXDONE; gi <= B_RSTRT; gi++) begin : g_flag
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          flag_q[gi] <= FLAG_RST[gi];
        end else if (!en_q) begin
          flag_q[gi] <= 1'b0;
        end else if (set_vec[gi]) begin
          flag_q[gi] <= 1'b1;
        end else if (clr_vec[gi]) begin
          flag_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Unmasked view of every flag
  assign raw = {hold_lvl, flag_q, i_low_raw};
  // Mask is active low: a zero hides the event
  assign masked = raw & mask_q;

  // Registered: one cycle of interrupt latency traded for glitch-free levels
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      masked_q <= FLAG_RST;
      irq_q <= 1'b0;
    end else begin
      masked_q <= masked;
      irq_q <= |masked;
    end
  end

  assign o_masked = masked_q;
  assign o_irq = irq_q;
  assign o_enabled = en_q;

  // Read data one cycle after the strobe; upper bits stay zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rdata_q <= RD_ZERO;
    end else if (i_req.rd) begin
      case (i_req.addr)
        OFF_RAW: begin
          rdata_q <= {{(DW-FW){1'b0}}, raw};
        end
        OFF_MSTAT: begin
          rdata_q <= {{(DW-FW){1'b0}}, masked};
        end
        OFF_MASK: begin
          rdata_q <= {{(DW-FW){1'b0}}, mask_q};
        end
        OFF_CTRL: begin
          rdata_q <= {21'h00_0000, ctrl_q};
        end
        OFF_CFG: begin
          rdata_q <= {29'h0000_0000, cfg_q};
        end
        OFF_ENABLE: begin
          rdata_q <= {31'h0000_0000, en_q};
        end
        OFF_CLR_ALL: begin
          rdata_q <= {31'h0000_0000, |raw};
        end
        OFF_CLR_ACT: begin
          rdata_q <= {31'h0000_0000, flag_q[B_ACT]};
        end
        OFF_CLR_GC: begin
          rdata_q <= {31'h0000_0000, flag_q[B_GC]};
        end
        default: begin
          rdata_q <= RD_ZERO;
        end
      endcase
    end else begin
      rdata_q <= RD_ZERO;
    end
  end

  assign o_rdata = rdata_q;

endmodule

// ---- tb/i2res_status_props.sv ----
// Checker of the raw event status block.
// Assumes the bench unmasks bit 10 before it enables the block.
`timescale 1ns/1ps
module i2res_status_props
  import i2res_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register port and bus
  input wire i2res_req_s i_req,
  input wire logic [DW-1:0] o_rdata,
  input wire logic i_scl,
  input wire logic i_sda,
  // Core and outputs
  input wire i2res_core_s i_core,
  input wire logic [B_LOW_TOP:0] i_low_raw,
  input wire logic o_enabled,
  input wire logic o_rx_store_en,
  input wire logic [FW-1:0] o_masked,
  input wire logic o_irq
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  sequence s_raw_rd;
    i_req.rd && i_req.addr == OFF_RAW && o_enabled;
  endsequence
  // One quiet cycle, so nothing clears or disables in between
  sequence s_quiet;
    !i_req.rd && !i_req.wr;
  endsequence
  AST_IRQ: assert property (o_irq == |o_masked)
    else $error("irq level wrong");
  AST_IDLE_RD: assert property (!$past(i_req.rd) |-> o_rdata == RD_ZERO)
    else $error("read data outside read slot");
  AST_RSV: assert property (o_rdata[DW-1:FW] == '0)
    else $error("reserved bits set");
  AST_GC_SET: assert property (i_core.gc_ack && o_enabled ##1 s_quiet ##1 s_raw_rd |=> o_rdata[B_GC])
    else $error("broadcast flag missing");
  AST_GC_CLR: assert property ((i_req.rd && i_req.addr == OFF_CLR_GC && !i_core.gc_ack)
    ##1 !i_core.gc_ack ##1 s_raw_rd |=> !o_rdata[B_GC])
    else $error("broadcast flag not cleared");
  AST_TXDONE: assert property (i_core.slv_tx_nack && i_core.slave_mode && o_enabled
    ##1 s_quiet ##1 s_raw_rd |=> o_rdata[B_TXDONE])
    else $error("tx done flag missing");
  AST_STORE: assert property (i_core.gc_ack && o_enabled
    |-> o_rx_store_en ##1 (o_rx_store_en || !o_enabled))
    else $error("broadcast data not stored");
  AST_OFF_CLR: assert property (!o_enabled ##1 (!o_enabled && i_req.rd && i_req.addr == OFF_RAW)
    |=> o_rdata[B_RSTRT:B_TXDONE] == '0)
    else $error("flags kept while disabled");
  AST_NO_SIDE: assert property (s_raw_rd ##1 s_quiet ##1 s_raw_rd
    |=> (o_rdata & $past(o_rdata, 2) & 32'h0000_1f80) == ($past(o_rdata, 2) & 32'h0000_1f80))
    else $error("raw read cleared a flag");
  AST_START: assert property (o_enabled && i_scl && $past(i_scl) && $fell(i_sda)
    |-> ##[1:6] (o_masked[B_START] || !o_enabled))
    else $error("start flag missing");
endmodule
bind i2res_status i2res_status_props i2res_status_props_inst (.i_clk, .i_rst_b, .i_req,
  .o_rdata, .i_scl, .i_sda, .i_core, .i_low_raw, .o_enabled, .o_rx_store_en, .o_masked, .o_irq);

// ---- tb/i2res_bus_model.sv ----
// Far-side bus master model that makes start, repeat and stop.
// Assumes pull-ups, so both lines rest high outside frames.
`timescale 1ns/1ps
module i2res_bus_model
(
  // Bus lines
  output logic o_scl,
  output logic o_sda
);
  localparam int unsigned HALF_NS = 200;
  // Keeps pad edges away from the sampling clock edge
  localparam int unsigned SKEW_NS = 7;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // From a low clock this gives a repeated start
  task automatic do_start();
    #SKEW_NS;
    o_sda = 1'b1;
    #HALF_NS;
    o_scl = 1'b1;
    #HALF_NS;
    o_sda = 1'b0;
    #HALF_NS;
    o_scl = 1'b0;
  endtask
  task automatic do_stop();
    #SKEW_NS;
    o_sda = 1'b0;
    #HALF_NS;
    o_scl = 1'b1;
    #HALF_NS;
    o_sda = 1'b1;
  endtask
endmodule

// ---- tb/i2res_status_test.sv ----
// Bench of the raw event status block.
// Assumes the bus model and the bound checker are compiled first.
`timescale 1ns/1ps
module i2res_status_test
  import i2res_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  i2res_req_s i_req = '0;
  i2res_core_s i_core = '0;
  logic [B_LOW_TOP:0] i_low_raw = '0;
  logic [DW-1:0] o_rdata, rd_val;
  logic [FW-1:0] o_masked;
  logic o_enabled, o_rx_store_en, o_irq, scl, sda;
  int fails = 0;
  int checked = 0;
  always #25 i_clk = ~i_clk;
  i2res_bus_model bus_model_inst (.o_scl(scl), .o_sda(sda));
  i2res_status i2res_status_inst (.i_clk, .i_rst_b, .i_req, .o_rdata, .i_scl(scl),
    .i_sda(sda), .i_core, .i_low_raw, .o_enabled, .o_rx_store_en, .o_masked, .o_irq);
  task automatic test_done();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [DW-1:0] e, input logic [DW-1:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic bchk(input string what, input logic e, input int unsigned b);
    checked++;
    if (rd_val[b] !== e) begin
      fails++;
      $display("unexpected %s: expected %b seen %b", what, e, rd_val[b]);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_clk);
    i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    i_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a);
    @(posedge i_clk);
    i_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    i_req.rd <= 1'b0;
    #1;
    rd_val = o_rdata;
  endtask
  task automatic bit_is(input string what, input int unsigned b, input logic e);
    rd(OFF_RAW);
    bchk(what, e, b);
  endtask
  task automatic core(input logic [7:0] v);
    @(posedge i_clk);
    i_core <= i2res_core_s'(v);
  endtask
  // Pulse p over levels v, then read raw status
  task automatic evt(input logic [7:0] v, input logic [7:0] p);
    core(v | p);
    core(v);
    rd(OFF_RAW);
  endtask
  task automatic settle();
    repeat (8) @(posedge i_clk);
  endtask
  task automatic t_reset();
    rd(OFF_RAW);
    chk("raw", RD_ZERO, rd_val);
    rd(OFF_MASK);
    chk("mask", 32'(MASK_RST), rd_val);
    rd(8'hfc);
    chk("unmapped", RD_ZERO, rd_val);
    wr(OFF_MASK, 32'h0000_3fff);
    wr(OFF_ENABLE, 32'h0000_0001);
    #1;
    chk("enable", 32'h0000_0001, 32'(o_enabled));
    $display("reset test done");
  endtask
  task automatic t_bus();
    bus_model_inst.do_start();
    settle();
    bit_is("start", B_START, 1'b1);
    bit_is("activity", B_ACT, 1'b1);
    bus_model_inst.do_stop();
    settle();
    bit_is("stop", B_STOP, 1'b1);
    rd(OFF_CLR_ACT);
    chk("act clear data", 32'h0000_0001, rd_val);
    bit_is("act clear", B_ACT, 1'b0);
    evt(8'h00, 8'h01);
    rd(OFF_CLR_ALL);
    chk("clear all data", 32'h0000_0001, rd_val);
    bit_is("global clear", B_ACT, 1'b0);
    evt(8'h80, 8'h10);
    bchk("broadcast", 1'b1, B_GC);
    chk("rx store", 32'h0000_0001, 32'(o_rx_store_en));
    rd(OFF_CLR_GC);
    chk("gc clear data", 32'h0000_0001, rd_val);
    bit_is("gc clear", B_GC, 1'b0);
    evt(8'h80, 8'h08);
    bchk("tx done", 1'b1, B_TXDONE);
    $display("bus test done");
  endtask
  // Stop after a frame carrying pulse bits of v, levels held
  task automatic stop_case(input string what, input logic [7:0] v, input logic e);
    wr(OFF_CLR_ALL, 32'h0000_1f80);
    core(v & 8'hc0);
    bus_model_inst.do_start();
    core(v);
    core(v & 8'hc0);
    bus_model_inst.do_stop();
    settle();
    bit_is(what, B_STOP, e);
  endtask
  task automatic t_stop();
    wr(OFF_CTRL, 32'h0000_0080);
    stop_case("unaddressed", 8'h80, 1'b0);
    stop_case("broadcast", 8'h90, 1'b0);
    stop_case("addressed", 8'ha0, 1'b1);
    wr(OFF_CTRL, 32'h0000_0400);
    stop_case("master idle", 8'h00, 1'b0);
    stop_case("master busy", 8'h40, 1'b1);
    $display("stop test done");
  endtask
  task automatic rs_case(input string what, input logic [2:0] cfg, input logic [7:0] v,
    input logic e);
    wr(OFF_CFG, 32'(cfg));
    wr(OFF_CLR_ALL, 32'h0000_1f80);
    core(8'h80 | v);
    bus_model_inst.do_start();
    core(8'ha0 | v);
    core(8'h80 | v);
    bus_model_inst.do_start();
    settle();
    bit_is(what, B_RSTRT, e);
    bus_model_inst.do_stop();
    settle();
  endtask
  task automatic t_rs();
    rs_case("restart", 3'h4, 8'h00, 1'b1);
    rs_case("restart hs", 3'h4, 8'h02, 1'b0);
    rs_case("restart off", 3'h0, 8'h00, 1'b0);
    $display("restart test done");
  endtask
  task automatic t_irq();
    evt(8'h04, 8'h10);
    wr(OFF_MASK, RD_ZERO);
    @(posedge i_clk);
    #1;
    chk("irq masked", RD_ZERO, 32'(o_irq));
    bit_is("raw unmasked", B_GC, 1'b1);
    wr(OFF_MASK, 32'h0000_0800);
    @(posedge i_clk);
    #1;
    chk("irq", 32'h0000_0001, 32'(o_irq));
    chk("masked port", 32'h0000_0800, 32'(o_masked));
    rd(OFF_MSTAT);
    chk("masked status", 32'h0000_0800, rd_val);
    for (int c = 0; c < 4; c++) begin
      wr(OFF_CFG, 32'(c));
      bit_is("hold", B_HOLD, c == 3);
    end
    core(8'h00);
    i_low_raw <= 7'h41;
    rd(OFF_RAW);
    chk("low bits", 32'h0000_0041, 32'(rd_val[B_LOW_TOP:0]));
    wr(OFF_ENABLE, RD_ZERO);
    bit_is("disabled", B_GC, 1'b0);
    chk("rx store off", RD_ZERO, 32'(o_rx_store_en));
    $display("irq test done");
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_reset();
    t_bus();
    t_stop();
    t_rs();
    t_irq();
    test_done();
  end
endmodule
